// *** common/itm_pkg.sv ***
// Shared constants and types for the serial bus timing master
`default_nettype none

package itm_pkg;

	// Register offsets
	localparam logic [15:0] REG_DIV = 16'h0430;
	localparam logic [15:0] REG_SHI = 16'h3814;
	localparam logic [15:0] REG_SLO = 16'h3818;
	localparam logic [15:0] REG_FHI = 16'h381c;
	localparam logic [15:0] REG_FLO = 16'h3820;

	// Divider field sits in bits 7-0
	localparam int DIV_MSB = 7;

	// Reset values and write floors
	localparam logic [7:0]  RST_DIV = 8'h00;
	localparam logic [15:0] MIN_HI  = 16'h0006;
	localparam logic [15:0] MIN_LO  = 16'h0008;

	// Ticks added to the programmed counts; FREE_FAST is a fixed count
	localparam logic [17:0] ADD_START   = 18'h00003;
	localparam logic [17:0] ADD_LOW     = 18'h00001;
	localparam logic [17:0] ADD_HIGH    = 18'h00008;
	localparam logic [17:0] ADD_RS_STD  = 18'h00011;
	localparam logic [17:0] ADD_RS_FAST = 18'h00087;
	localparam logic [17:0] ADD_RS_HOLD = 18'h00002;
	localparam logic [17:0] ADD_SP      = 18'h00007;
	localparam logic [17:0] ADD_FREE    = 18'h0000a;
	localparam logic [17:0] FREE_FAST   = 18'h00080;

	typedef enum logic [3:0] {
		PH_IDLE, PH_START, PH_WAIT, PH_LOW, PH_HIGH, PH_RS_LOW,
		PH_RS_SETUP, PH_RS_HOLD, PH_SP_LOW, PH_SP_SETUP, PH_FREE
	} itm_phase_t;

	typedef enum logic [1:0] {OP_START, OP_WRITE, OP_READ, OP_STOP} itm_op_t;

	typedef struct packed {
		itm_op_t    op;
		logic [7:0] data;
		logic       ack;
	} itm_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       nack;
	} itm_res_t;

	typedef struct packed {
		itm_phase_t    ph;
		logic [17:0]   cnt;
		logic          fast;
		logic          entered;
		logic [7:0]    div_cnt;
		logic          tick;
		logic [7:0]    div;
		logic [15:0]   shi;
		logic [15:0]   slo;
		logic [15:0]   fhi;
		logic [15:0]   flo;
		itm_cmd_t [1:0] fifo;
		logic [1:0]    fill;
		itm_op_t       op;
		logic [3:0]    bit_n;
		logic [8:0]    sh;
		logic          hold_done;
		logic          scl_drv;
		logic          sda_drv;
		logic          sda_m;
		logic          sda_s;
		logic          scl_m;
		logic          scl_s;
		itm_res_t      res;
		logic          res_valid;
		logic [15:0]   rdata;
	} itm_state_t;

endpackage

`default_nettype wire

// *** core/itm_master.sv ***
// Serial bus master: tick divider, bus phase timing, command buffer
// Operation
// - Tick comes from core clock divided by divider field plus one.
// - Standard: START hold lasts high count plus 3 ticks.
// - Standard: SCL low lasts low count plus 1 tick.
// - Standard: SCL high lasts high count plus 8 ticks.
// - Standard: repeated START set-up is high plus low plus 17 ticks.
// - Standard: repeated START hold is high count plus 2 ticks.
// - Standard: STOP set-up is high count plus 7 ticks.
// - Standard: bus free after STOP is low count plus 10 ticks.
// - Fast: START hold lasts fast high count plus 3 ticks.
// - Fast: SCL low lasts fast low count plus 1 tick.
// - Fast: SCL high lasts fast high count plus 8 ticks.
// - Fast: repeated START set-up is fast high count plus 135 ticks.
// - Fast: repeated START hold is fast high count plus 2 ticks.
// - Fast: STOP set-up is fast high count plus 7 ticks.
// - Fast: bus free after STOP is always 128 ticks.
// - SDA stays stable at least 1 tick after SCL falls.
// - Counts written below 6 (high) or 8 (low) store the minimum.
`default_nettype none

module itm_master
	import itm_pkg::*;
(
	// Clock and reset
	input  wire logic      CLK_SYS,
	input  wire logic      RSTN,
	// Register port
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [15:0] REG_WDATA,
	input  wire logic      REG_WR,
	input  wire logic      REG_RD,
	output logic [15:0]    REG_RDATA,
	// Speed select and status
	input  wire logic      FAST_MODE,
	output logic           BUSY,
	// Command stream
	input  wire itm_cmd_t  CMD,
	input  wire logic      CMD_VALID,
	output logic           CMD_READY,
	// Byte results
	output itm_res_t       RES,
	output logic           RES_VALID,
	input  wire logic      RES_READY,
	// Bus pins
	input  wire logic      SCL_I,
	output logic           SCL_O,
	output logic           SCL_OE_N,
	input  wire logic      SDA_I,
	output logic           SDA_O,
	output logic           SDA_OE_N
);

	itm_state_t st;
	itm_state_t next_st;
	itm_phase_t next_ph;
	logic       adv;
	logic       done;
	logic       pop;
	logic       push;
	logic [1:0] f;
	itm_cmd_t   head;

	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
		clamp = (v < lim) ? lim : v;
	endfunction

	function automatic logic [17:0] dur(input itm_phase_t p, input logic fm,
		input logic [15:0] h, input logic [15:0] l);
		logic [17:0] h18;
		logic [17:0] l18;
		h18 = {2'b00, h};
		l18 = {2'b00, l};
		case (p)
			PH_START:    dur = h18 + ADD_START;
			PH_HIGH:     dur = h18 + ADD_HIGH;
			PH_RS_SETUP: dur = fm ? h18 + ADD_RS_FAST : h18 + l18 + ADD_RS_STD;
			PH_RS_HOLD:  dur = h18 + ADD_RS_HOLD;
			PH_SP_SETUP: dur = h18 + ADD_SP;
			PH_FREE:     dur = fm ? FREE_FAST : l18 + ADD_FREE;
			default:     dur = l18 + ADD_LOW;
		endcase
	endfunction

	function automatic logic is_low(input itm_phase_t p);
		is_low = (p == PH_LOW) || (p == PH_RS_LOW) || (p == PH_SP_LOW);
	endfunction

	assign head      = st.fifo[0];
	assign CMD_READY = (st.fill != 2'h2);
	assign push      = CMD_VALID && CMD_READY;
	assign BUSY      = (st.ph != PH_IDLE);
	assign REG_RDATA = st.rdata;
	assign RES       = st.res;
	assign RES_VALID = st.res_valid;
	assign SCL_O     = 1'b0;
	assign SDA_O     = 1'b0;
	assign SCL_OE_N  = ~st.scl_drv;
	assign SDA_OE_N  = ~st.sda_drv;

	always_comb begin
		next_st = st;
		next_ph = st.ph;
		pop = 1'b0;
		next_st.entered = 1'b0;

		// Pin synchronisers
		next_st.sda_m = SDA_I;
		next_st.sda_s = st.sda_m;
		next_st.scl_m = SCL_I;
		next_st.scl_s = st.scl_m;

		// Tick divider
		next_st.tick = 1'b0;
		if (st.div_cnt >= st.div) begin
			next_st.div_cnt = 8'h00;
			next_st.tick = 1'b1;
		end else begin
			next_st.div_cnt = st.div_cnt + 8'h01;
		end

		// Register writes, count registers floored at the minimum
		if (REG_WR) begin
			case (REG_ADDR)
				REG_DIV: next_st.div = REG_WDATA[DIV_MSB:0];
				REG_SHI: next_st.shi = clamp(REG_WDATA, MIN_HI);
				REG_SLO: next_st.slo = clamp(REG_WDATA, MIN_LO);
				REG_FHI: next_st.fhi = clamp(REG_WDATA, MIN_HI);
				REG_FLO: next_st.flo = clamp(REG_WDATA, MIN_LO);
				default: ;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				REG_DIV: next_st.rdata = {8'h00, st.div};
				REG_SHI: next_st.rdata = st.shi;
				REG_SLO: next_st.rdata = st.slo;
				REG_FHI: next_st.rdata = st.fhi;
				REG_FLO: next_st.rdata = st.flo;
				default: next_st.rdata = 16'h0000;
			endcase
		end

		if (st.res_valid && RES_READY) begin
			next_st.res_valid = 1'b0;
		end

		// Counting; SCL held low by a slave stretches the high phase
		adv  = st.tick && (st.ph != PH_HIGH || st.scl_s);
		done = adv && (st.cnt == 18'h00000);
		if (adv && st.cnt != 18'h00000) begin
			next_st.cnt = st.cnt - 18'h00001;
		end

		// Data changes only after the first tick of a low phase
		if (is_low(st.ph) && st.tick && !st.hold_done) begin
			next_st.hold_done = 1'b1;
			case (st.ph)
				PH_LOW:    next_st.sda_drv = ~st.sh[8];
				PH_RS_LOW: next_st.sda_drv = 1'b0;
				default:   next_st.sda_drv = 1'b1;
			endcase
		end

		case (st.ph)
			PH_IDLE: begin
				if (st.fill != 2'h0) begin
					pop = 1'b1;
					if (head.op == OP_START) begin
						next_st.sda_drv = 1'b1;
						next_ph = PH_START;
					end
				end
			end
			PH_START: begin
				if (done) begin
					next_st.scl_drv = 1'b1;
					next_ph = PH_WAIT;
				end
			end
			PH_WAIT: begin
				// A pending result stalls the bus with SCL low
				if (st.fill != 2'h0 && !st.res_valid) begin
					pop = 1'b1;
					next_st.op = head.op;
					next_st.hold_done = 1'b0;
					next_st.bit_n = 4'h0;
					case (head.op)
						OP_START: next_ph = PH_RS_LOW;
						OP_STOP:  next_ph = PH_SP_LOW;
						OP_WRITE: begin
							next_st.sh = {head.data, 1'b1};
							next_ph = PH_LOW;
						end
						default: begin
							next_st.sh = {8'hff, ~head.ack};
							next_ph = PH_LOW;
						end
					endcase
				end
			end
			PH_LOW: begin
				if (done) begin
					next_st.scl_drv = 1'b0;
					next_ph = PH_HIGH;
				end
			end
			PH_HIGH: begin
				if (done) begin
					// Sampled at the end of high; slave set-up is its duty
					next_st.sh = {st.sh[7:0], st.sda_s};
					next_st.scl_drv = 1'b1;
					next_st.hold_done = 1'b0;
					if (st.bit_n == 4'h8) begin
						next_st.res.data = st.sh[7:0];
						next_st.res.nack = st.sda_s;
						next_st.res_valid = 1'b1;
						next_ph = PH_WAIT;
					end else begin
						next_st.bit_n = st.bit_n + 4'h1;
						next_ph = PH_LOW;
					end
				end
			end
			PH_RS_LOW: begin
				if (done) begin
					next_st.scl_drv = 1'b0;
					next_ph = PH_RS_SETUP;
				end
			end
			PH_RS_SETUP: begin
				if (done) begin
					next_st.sda_drv = 1'b1;
					next_ph = PH_RS_HOLD;
				end
			end
			PH_RS_HOLD: begin
				if (done) begin
					next_st.scl_drv = 1'b1;
					next_ph = PH_WAIT;
				end
			end
			PH_SP_LOW: begin
				if (done) begin
					next_st.scl_drv = 1'b0;
					next_ph = PH_SP_SETUP;
				end
			end
			PH_SP_SETUP: begin
				if (done) begin
					next_st.sda_drv = 1'b0;
					next_ph = PH_FREE;
				end
			end
			PH_FREE: begin
				if (done) begin
					next_ph = PH_IDLE;
				end
			end
			default: begin
				next_st.scl_drv = 1'b0;
				next_st.sda_drv = 1'b0;
				next_ph = PH_IDLE;
			end
		endcase

		// Phase load picks the active count pair
		if (next_ph != st.ph) begin
			next_st.entered = 1'b1;
			next_st.fast = FAST_MODE;
			next_st.cnt = dur(next_ph, FAST_MODE,
				FAST_MODE ? st.fhi : st.shi,
				FAST_MODE ? st.flo : st.slo) - 18'h00001;
		end
		next_st.ph = next_ph;

		// Two-entry command buffer
		f = st.fill;
		if (pop) begin
			next_st.fifo[0] = st.fifo[1];
			f = f - 2'h1;
		end
		if (push) begin
			next_st.fifo[f[0]] = CMD;
			f = f + 2'h1;
		end
		next_st.fill = f;
	end

	always_ff @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			st <= '0;
			st.ph <= PH_IDLE;
			st.div <= RST_DIV;
			st.shi <= MIN_HI;
			st.slo <= MIN_LO;
			st.fhi <= MIN_HI;
			st.flo <= MIN_LO;
			st.sda_m <= 1'b1;
			st.sda_s <= 1'b1;
			st.scl_m <= 1'b1;
			st.scl_s <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// Checks
	logic [15:0] hi_sel;
	logic [15:0] lo_sel;
	assign hi_sel = st.fast ? st.fhi : st.shi;
	assign lo_sel = st.fast ? st.flo : st.slo;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RSTN);

	chk_tick_gap: assert property (st.tick && st.div == 8'h01 |=> !st.tick ##1 st.tick)
		else $error("tick spacing wrong for divider 1");
	chk_start_len: assert property (st.entered && st.ph == PH_START |->
		st.cnt == {2'b00, hi_sel} + ADD_START - 18'h00001)
		else $error("start hold length wrong");
	chk_low_len: assert property (st.entered && is_low(st.ph) |->
		st.cnt == {2'b00, lo_sel} + ADD_LOW - 18'h00001 && !SCL_OE_N)
		else $error("low phase length wrong");
	chk_high_len: assert property (st.entered && st.ph == PH_HIGH |->
		st.cnt == {2'b00, hi_sel} + ADD_HIGH - 18'h00001 && SCL_OE_N)
		else $error("high phase length wrong");
	chk_rs_setup: assert property (st.entered && st.ph == PH_RS_SETUP |->
		st.cnt == (st.fast ? {2'b00, hi_sel} + ADD_RS_FAST
		: {2'b00, hi_sel} + {2'b00, lo_sel} + ADD_RS_STD) - 18'h00001)
		else $error("repeated start set-up wrong");
	chk_rs_hold: assert property (st.entered && st.ph == PH_RS_HOLD |->
		st.cnt == {2'b00, hi_sel} + ADD_RS_HOLD - 18'h00001 && !SDA_OE_N)
		else $error("repeated start hold wrong");
	chk_stop_setup: assert property (st.entered && st.ph == PH_SP_SETUP |->
		st.cnt == {2'b00, hi_sel} + ADD_SP - 18'h00001)
		else $error("stop set-up wrong");
	chk_bus_free: assert property (st.entered && st.ph == PH_FREE |->
		st.cnt == (st.fast ? FREE_FAST : {2'b00, lo_sel} + ADD_FREE) - 18'h00001)
		else $error("bus free time wrong");
	chk_count_floor: assert property (st.shi >= MIN_HI && st.fhi >= MIN_HI
		&& st.slo >= MIN_LO && st.flo >= MIN_LO)
		else $error("timing count below minimum");
	chk_count_gate: assert property (!st.tick && st.ph != PH_IDLE && st.ph != PH_WAIT
		|=> $stable(st.cnt))
		else $error("counter moved without tick");
	// With SCL low, data may move only once a tick has passed since the fall
	chk_sda_hold: assert property ($changed(st.sda_drv) && st.scl_drv
		|-> $past(st.scl_drv) && $past(st.tick))
		else $error("data changed with SCL fall");
	chk_mode_pick: assert property (st.entered |-> st.fast == $past(FAST_MODE))
		else $error("count pair not from speed select");

	cov_start: cover property (st.entered && st.ph == PH_START);
	cov_byte: cover property (RES_VALID && RES_READY);
	cov_rstart: cover property (st.entered && st.ph == PH_RS_HOLD);
	cov_fast_free: cover property (st.entered && st.ph == PH_FREE && st.fast);

endmodule

`default_nettype wire

// *** dv/itm_master_bench.sv ***
// Self-checking bench for the serial bus timing master
`default_nettype none

module itm_master_bench;
	import itm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	logic        CLK_SYS, RSTN, REG_WR, REG_RD, FAST_MODE, CMD_VALID, RES_READY;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic        BUSY, CMD_READY, RES_VALID, SCL_O, SCL_OE_N, SDA_O, SDA_OE_N, s_oe_n;
	itm_cmd_t    CMD;
	itm_res_t    RES;
	int          fails = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          i;
	// Pull-ups on both lines; the target never stretches the clock
	wire logic   scl = SCL_OE_N;
	wire logic   sda = SDA_OE_N & s_oe_n;
	logic [15:0] ra[5] = '{REG_DIV, REG_SHI, REG_SLO, REG_FHI, REG_FLO};
	logic [15:0] rv[5] = '{16'h0000, 16'h0006, 16'h0008, 16'h0006, 16'h0008};
	itm_op_t     ops[8] = '{OP_START, OP_WRITE, OP_START, OP_WRITE, OP_READ, OP_STOP, OP_START, OP_STOP};
	logic [7:0]  dat[8] = '{8'h00, 8'ha4, 8'h00, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00};

	itm_master i_itm_master (.CLK_SYS, .RSTN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.FAST_MODE, .BUSY, .CMD, .CMD_VALID, .CMD_READY, .RES, .RES_VALID, .RES_READY,
		.SCL_I(scl), .SCL_O, .SCL_OE_N, .SDA_I(sda), .SDA_O, .SDA_OE_N);
	itm_slave i_itm_slave (.scl(scl), .sda(sda), .sda_oe_n(s_oe_n));

	initial begin
		CLK_SYS = 1'b0;
		forever #50 CLK_SYS = ~CLK_SYS;
	end

	always @(posedge CLK_SYS) cyc++;

	task automatic stp(int n = 1);
		repeat (n) @(posedge CLK_SYS);
		#5;
	endtask

	task automatic cmp(logic [31:0] got, logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Cycle counts; slack covers sync delay and tick alignment
	task automatic dur(int got, int exp, int slack);
		n_compared++;
		if (got < exp || got > exp + slack) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(logic [15:0] a, logic [15:0] d);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'b1;
		stp();
		REG_WR = 1'b0;
		stp();
	endtask

	task automatic rdc(logic [15:0] a, logic [15:0] exp);
		REG_ADDR = a;
		REG_RD = 1'b1;
		stp();
		REG_RD = 1'b0;
		cmp(REG_RDATA, exp);
		stp();
	endtask

	task automatic push(itm_op_t op, logic [7:0] d);
		int n;
		CMD = '{op, d, 1'b0};
		CMD_VALID = 1'b1;
		for (n = 0; n < 20000 && CMD_READY !== 1'b1; n++) stp();
		stp();
	endtask

	task automatic collect();
		itm_res_t e[3];
		int       k;
		int       n;
		e = '{'{8'ha4, 1'b0}, '{8'ha5, 1'b0}, '{8'hc3, 1'b1}};
		for (k = 0; k < 3; k++) begin
			for (n = 0; n < 20000 && RES_VALID !== 1'b1; n++) stp();
			if (k == 0) begin
				stp(100);
				cmp(CMD_READY, 32'h0);
				cmp(RES_VALID, 32'h1);
			end
			cmp(RES, e[k]);
			RES_READY = 1'b1;
			stp();
			RES_READY = 1'b0;
		end
	endtask

	task automatic meas(int hi, int lo, int k, logic fast);
		int t;
		@(negedge sda) t = cyc;
		// First tick after an idle load may come up to one divider span early
		@(negedge scl) dur(cyc - t, (hi + 3) * k - k + 1, k - 1);
		// Second bit, where low and high follow each other with no wait
		@(posedge scl);
		@(negedge scl) t = cyc;
		@(posedge scl) dur(cyc - t, (lo + 1) * k, 0);
		t = cyc;
		@(negedge scl) dur(cyc - t, (hi + 8) * k, k + 2);
		repeat (7) @(negedge scl);
		@(posedge scl) t = cyc;
		@(negedge sda) dur(cyc - t, fast ? (hi + 135) * k : (hi + lo + 17) * k, k + 2);
		t = cyc;
		@(negedge scl) dur(cyc - t, (hi + 2) * k, 0);
		repeat (18) @(negedge scl);
		@(posedge scl) t = cyc;
		@(posedge sda) dur(cyc - t, (hi + 7) * k, k + 2);
		t = cyc;
		@(negedge sda) dur(cyc - t, fast ? 128 * k : (lo + 10) * k, k + 3);
	endtask

	task automatic txn(int hi, int lo, int k, logic fast);
		int n;
		FAST_MODE = fast;
		fork
			meas(hi, lo, k, fast);
			collect();
			begin
				for (n = 0; n < 8; n++) push(ops[n], dat[n]);
				CMD_VALID = 1'b0;
			end
		join
		for (n = 0; n < 20000 && BUSY !== 1'b0; n++) stp();
		cmp(BUSY, 32'h0);
		// Idle bus: both lines released, pin data levels stay low
		cmp({SCL_O, SDA_O, SCL_OE_N, SDA_OE_N}, 32'h3);
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#2_000_000;
		fails++;
		final_report();
	end

	initial begin
		RSTN = 1'b0;
		REG_ADDR = 16'h0000;
		REG_WDATA = 16'h0000;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		FAST_MODE = 1'b0;
		CMD = '0;
		CMD_VALID = 1'b0;
		RES_READY = 1'b0;
		stp(8);
		RSTN = 1'b1;
		stp();
		for (i = 0; i < 5; i++) rdc(ra[i], rv[i]);
		wr(REG_SHI, 16'h0005);
		rdc(REG_SHI, 16'h0006);
		wr(REG_SLO, 16'h0007);
		rdc(REG_SLO, 16'h0008);
		wr(REG_FHI, 16'h0007);
		rdc(REG_FHI, 16'h0007);
		wr(REG_DIV, 16'hff01);
		rdc(REG_DIV, 16'h0001);
		wr(16'h0100, 16'h1234);
		rdc(16'h0100, 16'h0000);
		rdc(REG_DIV, 16'h0001);
		wr(REG_SHI, 16'h000a);
		wr(REG_SLO, 16'h000c);
		txn(10, 12, 2, 1'b0);
		wr(REG_FHI, 16'h0002);
		wr(REG_FLO, 16'h0003);
		wr(REG_DIV, 16'h0000);
		rdc(REG_FLO, 16'h0008);
		txn(6, 8, 1, 1'b1);
		final_report();
	end
endmodule

`default_nettype wire

// *** dv/itm_slave.sv ***
// Behavioural target device on the two-wire bus
`default_nettype none

module itm_slave #(
	parameter logic [7:0] RD_BYTE = 8'hc3
) (
	// Bus lines
	input  wire logic scl,
	input  wire logic sda,
	output var  logic sda_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [3:0] n   = 4'h0;
	logic [7:0] sh  = 8'h00;
	logic       rd  = 1'b0;
	logic       adr = 1'b0;
	logic       act = 1'b0;

	initial sda_oe_n = 1'b1;

	always @(negedge sda) if (scl) begin
		n = 4'h0;
		adr = 1'b1;
		act = 1'b1;
	end

	always @(posedge sda) if (scl) act = 1'b0;

	always @(posedge scl) if (act) begin
		if (n != 4'h8) begin
			sh = {sh[6:0], sda};
			n = n + 4'h1;
		end else begin
			n = 4'h0;
			// A refused read byte ends our part until the next START
			if (!adr && rd && sda) act = 1'b0;
			if (adr) rd = sh[0];
			adr = 1'b0;
		end
	end

	// Change data well inside the low phase, one tick or more after the fall
	always @(negedge scl) begin
		#250;
		if (!act) sda_oe_n = 1'b1;
		else if (n == 4'h8) sda_oe_n = rd && !adr;
		else sda_oe_n = (rd && !adr) ? RD_BYTE[4'h7 - n] : 1'b1;
	end
endmodule

`default_nettype wire
